/* File: sim/ued_dma_channel_test.sv */
// Self-checking bench for the endpoint DMA channel
`default_nettype none
module ued_dma_channel_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ued_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, eb_rdata = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, eb_ack = 1'b0;
  logic iso = 1'b0, pkt_rdy = 1'b0, pkt_data1 = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, pkt_done;
  logic irq_go, irq_rld, mem_ack, last_sel;
  logic [1:0] bresp, rresp, wresp;
  logic [PKT_W-1:0] pkt_len = 10'h000, max_pkt = 10'h010, pkt_cnt;
  logic [7:0] mem_rdata, pbase;
  logic [15:0] v;
  ued_eb_t eb;
  ued_mem_t mem;
  logic [31:0] seed = 32'd48319;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  int n_go = 0, n_rld = 0, s1, s2, t;
  logic [7:0] regs [6] = '{OFF_SIZE, OFF_AHI, OFF_ALO, OFF_RSIZE,
    OFF_RAHI, OFF_RALO};
  // Endpoint buffer contents written by IN transfers
  logic [7:0] ebm [0:255];

  ued_dma_channel dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .iso, .pkt_rdy,
    .pkt_data1, .pkt_len, .max_pkt, .pkt_done, .pkt_cnt, .eb, .eb_ack,
    .eb_rdata, .mem, .mem_ack, .mem_rdata, .irq_go, .irq_rld);
  ued_mem_model mem_model (.aclk, .aresetn, .mem, .mem_ack, .mem_rdata);

  always #50 aclk = ~aclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int rlen();
    return 1 + int'(rnd() % 8);
  endfunction : rlen
  function automatic logic [7:0] pat(input int i);
    return 8'(pbase + 8'(3 * i));
  endfunction : pat

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Endpoint buffer: one-cycle answer, byte pattern keyed by index
  always @(posedge aclk)
  begin
    cyc++;
    if (irq_go === 1'b1)
      n_go++;
    if (irq_rld === 1'b1)
      n_rld++;
    if (eb.req === 1'b1 && !eb_ack)
    begin
      eb_ack <= 1'b1;
      eb_rdata <= pat(int'(eb.idx));
      last_sel <= eb.sel;
      if (eb.we)
        ebm[eb.idx[7:0]] <= eb.data;
    end
    else
    begin
      eb_ack <= 1'b0;
      eb_rdata <= ~eb_rdata;
    end
    if (cyc > 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Each bus task ends one edge later so no signal is set twice at once
  task automatic wr(input logic [7:0] a, input logic [15:0] dv);
    awaddr <= a;
    wdata <= {16'h0000, dv};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    wresp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dv);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    dv = rdata;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] dv;
    rd(a, dv);
    check(dv, e);
  endtask : rchk

  task automatic send_pkt(input int len);
    int k = 0;
    pkt_len <= 10'(len);
    pkt_data1 <= 1'(rnd());
    pkt_rdy <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
    end
    while (pkt_done !== 1'b1 && k < 2000);
    check(32'(pkt_done), 1);
    check(32'(pkt_cnt), 32'(len));
    pkt_rdy <= 1'b0;
    @(posedge aclk);
  endtask : send_pkt

  task automatic wait_idle();
    int k = 0;
    do
    begin
      rd(OFF_CTRL, d);
      k++;
    end
    while (d[0] !== 1'b0 && k < 200);
  endtask : wait_idle

  task automatic chk_mem(input logic [7:0] a, input int n, input int len,
    input logic e);
    check(32'(mem_model.ram[a]), 32'(n >> 8));
    check(32'(mem_model.ram[8'(a + 1)]), 32'(n & 255));
    for (int k = 0; k < n; k++)
      check(32'(mem_model.ram[8'(a + 2 + k) ^ {7'h00, e}]),
        32'(pat(k % len)));
  endtask : chk_mem

  task automatic xfer(input logic [15:0] ct, input int len, input int np,
    input logic full);
    logic [7:0] a;
    int n;
    a = 8'(rnd() & 32'h7E);
    n = len * np;
    pbase = 8'(rnd());
    max_pkt <= full ? 10'(len) : 10'h010;
    wr(OFF_SIZE, 16'(n));
    wr(OFF_AHI, 16'(rnd() & 32'hFF));
    wr(OFF_ALO, {8'h00, a});
    wr(OFF_CTRL, ct | 16'h0021);
    rchk(OFF_COUNT, 0);
    for (int j = 0; j < np; j++)
    begin
      send_pkt(len);
      check(32'(last_sel), iso ? 32'(j % 2) : 32'(pkt_data1));
    end
    if (ct[4] && full)
    begin
      rd(OFF_CTRL, d);
      check(32'(d[0]), 1);
      send_pkt(0);
    end
    wait_idle();
    check(32'(d[0]), 0);
    rchk(OFF_COUNT, 32'(n));
    chk_mem(a, n, len, ct[2]);
  endtask : xfer

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 10; i++)
      rchk(8'(4 * i), 0);
    rd(8'h28, d);
    check(32'(rresp), 32'(RESP_SLVERR));
    wr(8'h28, 16'h1234);
    check(32'(wresp), 32'(RESP_SLVERR));
    for (int i = 0; i < 6; i++)
    begin
      v = 16'(rnd()) & ((i % 3 == 1) ? 16'h00FF : 16'hFFFE);
      wr(regs[i], v);
      rchk(regs[i], 32'(v));
    end
    wr(OFF_COUNT, 16'hFFFF);
    rchk(OFF_COUNT, 0);
    wr(OFF_CTRL, 16'h0022);
    rd(OFF_CTRL, d);
    check(32'(d[1]), 0);
    $display("test registers done");
    xfer(16'h0000, rlen(), 1, 1'b0);
    check(32'(n_go), 0);
    rchk(OFF_FLAGS, 1);
    wr(OFF_FLAGS, 16'h0003);
    wr(OFF_IRQEN, 16'h0001);
    for (int i = 0; i < 6; i++)
    begin
      xfer(16'(rnd() & 32'h1C), rlen(), 1, 1'b0);
      check(32'(n_go), 32'(i + 1));
    end
    $display("test random out done");
    iso <= 1'b1;
    xfer(16'h0000, 4, 3, 1'b1);
    iso <= 1'b0;
    xfer(16'h0010, 8, 1, 1'b1);
    check(32'(n_go), 8);
    $display("test iso and short packet done");
    wr(OFF_FLAGS, 16'h0003);
    s1 = rlen();
    s2 = rlen();
    max_pkt <= 10'h010;
    wr(OFF_RSIZE, 16'(s2));
    wr(OFF_RAHI, 16'h0000);
    wr(OFF_RALO, 16'h00A0);
    wr(OFF_SIZE, 16'(s1));
    wr(OFF_AHI, 16'h0000);
    wr(OFF_ALO, 16'h0010);
    wr(OFF_CTRL, 16'h0023);
    wr(OFF_CTRL, 16'h0021);
    rd(OFF_CTRL, d);
    check(32'(d[1]), 1);
    send_pkt(s1);
    t = 0;
    while (n_rld == 0 && t < 100)
    begin
      @(posedge aclk);
      t++;
    end
    check(32'(n_rld), 1);
    rchk(OFF_COUNT, 0);
    rd(OFF_CTRL, d);
    check(32'(d[1:0]), 1);
    rchk(OFF_FLAGS, 2);
    rchk(OFF_SIZE, 32'(s2));
    rchk(OFF_ALO, 32'h00A0);
    rchk(OFF_RSIZE, 32'(s1));
    rchk(OFF_RALO, 32'h0010);
    send_pkt(s2);
    wait_idle();
    rchk(OFF_COUNT, 32'(s2));
    check(32'(n_go), 9);
    chk_mem(8'h10, s1, s1, 1'b0);
    chk_mem(8'hA0, s2, s2, 1'b0);
    $display("test reload done");
    // IN direction: memory bytes from the first reload block go to buffer
    wr(OFF_SIZE, 16'(s1));
    wr(OFF_ALO, 16'h0012);
    wr(OFF_CTRL, 16'h0001);
    send_pkt(s1);
    check(32'(last_sel), 32'(pkt_data1));
    wait_idle();
    check(32'(d[0]), 0);
    rchk(OFF_COUNT, 32'(s1));
    for (int k = 0; k < s1; k++)
      check(32'(ebm[k]), 32'(pat(k)));
    check(32'(n_go), 10);
    $display("test in done");
    finish_test();
  end
endmodule : ued_dma_channel_test
`default_nettype wire

/* File: sim/ued_mem_model.sv */
// Byte-wide processor memory model answering after a random delay
`default_nettype none
module ued_mem_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire ued_pkg::ued_mem_t mem,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import ued_pkg::*;
  // Only the low 8 address bits are decoded, so addresses alias
  logic [7:0] ram [0:255];
  logic [15:0] lfsr_q;
  logic [1:0] wait_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
      lfsr_q <= 16'hACE1;
    else
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12]};
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= 8'h00;
    end
    else if (mem.req && !mem_ack && wait_q == 2'h0)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= ram[mem.addr[7:0]];
      if (mem.we)
        ram[mem.addr[7:0]] <= mem.data;
    end
    else
    begin
      // Stale read data is scrambled so nothing relies on it
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_ack)
        wait_q <= lfsr_q[1:0];
      else if (mem.req && wait_q != 2'h0)
        wait_q <= wait_q - 2'h1;
    end
  end
endmodule : ued_mem_model
`default_nettype wire

/* File: verilog/ued_addr_gen.sv */
// Byte address generator for processor memory accesses
`default_nettype none
module ued_addr_gen
(
  input wire logic [7:0] base_hi,
  input wire logic [15:0] base_lo,
  input wire logic [15:0] offset,
  input wire logic skip2,
  input wire logic swap,
  output logic [23:0] addr
);
  import ued_pkg::*;
  logic [23:0] sum;
  always_comb
  begin
    sum = {base_hi, base_lo} + {8'h00, offset};
    if (skip2)
    begin
      sum = sum + DATA_SKIP;
    end
    // Flipping bit 0 swaps the bytes of each aligned word
    addr = {sum[23:1], sum[0] ^ swap};
  end
endmodule : ued_addr_gen
`default_nettype wire

/* File: verilog/ued_dma_channel.sv */
// Endpoint DMA channel with AXI4-Lite register slave
`default_nettype none
module ued_dma_channel
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ued_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ued_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic iso,
  input wire logic pkt_rdy,
  input wire logic pkt_data1,
  input wire logic [ued_pkg::PKT_W-1:0] pkt_len,
  input wire logic [ued_pkg::PKT_W-1:0] max_pkt,
  output logic pkt_done,
  output logic [ued_pkg::PKT_W-1:0] pkt_cnt,
  output ued_pkg::ued_eb_t eb,
  input wire logic eb_ack,
  input wire logic [7:0] eb_rdata,
  output ued_pkg::ued_mem_t mem,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic irq_go,
  output logic irq_rld
);
  import ued_pkg::*;

  ued_state_t state_q;
  ued_ctrl_t ctrl_q;
  ued_ctrl_t wctl;
  logic [15:0] size_q, ahi_q, alo_q, rsize_q, rahi_q, ralo_q;
  logic [15:0] count_q, moved_q, agoff;
  logic en_q, irq_go_q, irq_rld_q, pkt_done_q;
  logic [1:0] flags_q, flag_set;
  logic [PKT_W-1:0] off_q, plen_q, pkt_cnt_q;
  logic iso_y_q, zlp_q;
  logic [7:0] byte_q;
  ued_eb_t eb_q;
  ued_mem_t mem_q;
  logic [23:0] ag_addr;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, rd_mux;
  logic [7:0] awaddr_q, wa, ra;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  logic wr_go, we_ctrl, start, xdone, pend, busy, ack, pkt_rel, fullp;

  function automatic logic [15:0] wmerge(input logic [15:0] o,
                                         input logic [15:0] d,
                                         input logic [1:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : wmerge

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign eb = eb_q;
  assign mem = mem_q;
  assign pkt_done = pkt_done_q;
  assign pkt_cnt = pkt_cnt_q;
  assign irq_go = irq_go_q;
  assign irq_rld = irq_rld_q;

  assign wa = {awaddr_q[7:2], 2'b00};
  assign ra = {araddr[7:2], 2'b00};
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign we_ctrl = wr_go && wa == OFF_CTRL && wstrb_q[0];
  assign wctl = ued_ctrl_t'(wdata_q[5:0]);
  assign start = we_ctrl && wctl.go && !ctrl_q.go;
  assign xdone = moved_q == size_q;
  assign pend = off_q == plen_q;
  assign busy = eb_q.req || mem_q.req;
  assign ack = (eb_ack && eb_q.req) || (mem_ack && mem_q.req);
  // Concatenation keeps a partly used packet for the reloaded transfer; a new go clears it
  assign pkt_rel = pend || !ctrl_q.concat_select;
  assign fullp = off_q == max_pkt;

  always_comb
  begin
    if (state_q == S_SVL)
    begin
      agoff = 16'h0001;
    end
    else if (state_q == S_SVH)
    begin
      agoff = 16'h0000;
    end
    else
    begin
      agoff = moved_q;
    end
  end

  // Low byte of the high address register only; upper bits are software's
  ued_addr_gen u_ag
  (
    .base_hi(ahi_q[7:0]),
    .base_lo(alo_q),
    .offset(agoff),
    .skip2(ctrl_q.dir_out && state_q != S_SVH && state_q != S_SVL),
    .swap(ctrl_q.endian && state_q != S_SVH && state_q != S_SVL),
    .addr(ag_addr)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'b00;
    end
    else
    begin
      if (awvalid && awready_q)
      begin
        awaddr_q <= awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q)
      begin
        wdata_q <= wdata[15:0];
        wstrb_q <= wstrb[1:0];
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wa <= OFF_FLAGS) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (ra == OFF_SIZE)
    begin
      rd_mux[15:0] = size_q;
    end
    else if (ra == OFF_COUNT)
    begin
      rd_mux[15:0] = count_q;
    end
    else if (ra == OFF_AHI)
    begin
      rd_mux[15:0] = ahi_q;
    end
    else if (ra == OFF_ALO)
    begin
      rd_mux[15:0] = alo_q;
    end
    else if (ra == OFF_CTRL)
    begin
      rd_mux[5:0] = ctrl_q;
    end
    else if (ra == OFF_RSIZE)
    begin
      rd_mux[15:0] = rsize_q;
    end
    else if (ra == OFF_RAHI)
    begin
      rd_mux[15:0] = rahi_q;
    end
    else if (ra == OFF_RALO)
    begin
      rd_mux[15:0] = ralo_q;
    end
    else if (ra == OFF_IRQEN)
    begin
      rd_mux[0] = en_q;
    end
    else if (ra == OFF_FLAGS)
    begin
      rd_mux[1:0] = flags_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= (ra <= OFF_FLAGS) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Primary and reload sets; the swap overrides a write in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      size_q <= RST_REG;
      ahi_q <= RST_REG;
      alo_q <= RST_REG;
      rsize_q <= RST_REG;
      rahi_q <= RST_REG;
      ralo_q <= RST_REG;
    end
    else if (state_q == S_END && ctrl_q.reload_request)
    begin
      size_q <= rsize_q;
      rsize_q <= size_q;
      ahi_q <= rahi_q;
      rahi_q <= ahi_q;
      alo_q <= ralo_q;
      ralo_q <= alo_q;
    end
    else if (wr_go)
    begin
      if (wa == OFF_SIZE) size_q <= wmerge(size_q, wdata_q, wstrb_q);
      if (wa == OFF_AHI) ahi_q <= wmerge(ahi_q, wdata_q, wstrb_q);
      if (wa == OFF_ALO) alo_q <= wmerge(alo_q, wdata_q, wstrb_q);
      if (wa == OFF_RSIZE) rsize_q <= wmerge(rsize_q, wdata_q, wstrb_q);
      if (wa == OFF_RAHI) rahi_q <= wmerge(rahi_q, wdata_q, wstrb_q);
      if (wa == OFF_RALO) ralo_q <= wmerge(ralo_q, wdata_q, wstrb_q);
    end
  end

  always_comb
  begin
    flag_set = 2'b00;
    if (state_q == S_END)
    begin
      flag_set[FLAG_RLD] = ctrl_q.reload_request;
      flag_set[FLAG_GO] = !ctrl_q.reload_request;
    end
  end

  // Control, enable and flags; hardware events win over software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= '0;
      en_q <= 1'b0;
      flags_q <= 2'b00;
      irq_go_q <= 1'b0;
      irq_rld_q <= 1'b0;
    end
    else
    begin
      if (we_ctrl)
      begin
        ctrl_q.endian <= wctl.endian;
        ctrl_q.concat_select <= wctl.concat_select;
        ctrl_q.short_packet_select <= wctl.short_packet_select;
        ctrl_q.dir_out <= wctl.dir_out;
        if (wctl.go)
        begin
          ctrl_q.go <= 1'b1;
        end
        if (wctl.reload_request && (ctrl_q.go || wctl.go))
        begin
          ctrl_q.reload_request <= 1'b1;
        end
      end
      if (wr_go && wa == OFF_IRQEN && wstrb_q[0])
      begin
        en_q <= wdata_q[0];
      end
      if (wr_go && wa == OFF_FLAGS && wstrb_q[0])
      begin
        flags_q <= (flags_q & ~wdata_q[1:0]) | flag_set;
      end
      else
      begin
        flags_q <= flags_q | flag_set;
      end
      irq_rld_q <= flag_set[FLAG_RLD] && en_q;
      irq_go_q <= flag_set[FLAG_GO] && en_q;
      if (state_q == S_END)
      begin
        if (ctrl_q.reload_request)
        begin
          ctrl_q.reload_request <= 1'b0;
        end
        else
        begin
          ctrl_q.go <= 1'b0;
        end
      end
    end
  end

  // Transfer engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= S_IDLE;
      count_q <= RST_REG;
      moved_q <= RST_REG;
      off_q <= '0;
      plen_q <= '0;
      iso_y_q <= 1'b0;
      zlp_q <= 1'b0;
      byte_q <= 8'h00;
      eb_q <= '0;
      mem_q <= '0;
      pkt_done_q <= 1'b0;
      pkt_cnt_q <= '0;
    end
    else
    begin
      pkt_done_q <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (start)
          begin
            count_q <= RST_REG;
            moved_q <= RST_REG;
            off_q <= '0;
            iso_y_q <= 1'b0;
            zlp_q <= 1'b0;
            state_q <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          // The cycle after a release is skipped so it is not taken twice
          if (pkt_rdy && !pkt_done_q)
          begin
            eb_q.sel <= iso ? iso_y_q : pkt_data1;
            plen_q <= ctrl_q.dir_out ? pkt_len : max_pkt;
            state_q <= S_CHK;
          end
        end
        S_CHK:
        begin
          if (xdone || pend)
          begin
            state_q <= ctrl_q.dir_out ? S_SVH : S_PKT;
          end
          else
          begin
            state_q <= S_RD;
          end
        end
        S_RD:
        begin
          if (ack)
          begin
            eb_q.req <= 1'b0;
            mem_q.req <= 1'b0;
            byte_q <= ctrl_q.dir_out ? eb_rdata : mem_rdata;
            state_q <= S_WR;
          end
          else if (!busy && ctrl_q.dir_out)
          begin
            eb_q.req <= 1'b1;
            eb_q.we <= 1'b0;
            eb_q.idx <= off_q;
          end
          else if (!busy)
          begin
            mem_q <= '{req: 1'b1, we: 1'b0, addr: ag_addr, data: 8'h00};
          end
        end
        S_WR:
        begin
          if (ack)
          begin
            eb_q.req <= 1'b0;
            mem_q.req <= 1'b0;
            moved_q <= moved_q + 16'h0001;
            off_q <= off_q + 1'b1;
            state_q <= S_CHK;
          end
          else if (!busy && ctrl_q.dir_out)
          begin
            mem_q <= '{req: 1'b1, we: 1'b1, addr: ag_addr, data: byte_q};
          end
          else if (!busy)
          begin
            eb_q.req <= 1'b1;
            eb_q.we <= 1'b1;
            eb_q.idx <= off_q;
            eb_q.data <= byte_q;
          end
        end
        S_SVH, S_SVL:
        begin
          if (ack)
          begin
            mem_q.req <= 1'b0;
            state_q <= (state_q == S_SVH) ? S_SVL : S_PKT;
          end
          else if (!busy)
          begin
            mem_q <= '{req: 1'b1, we: 1'b1, addr: ag_addr,
                       data: (state_q == S_SVH) ? moved_q[15:8] : moved_q[7:0]};
          end
        end
        S_PKT:
        begin
          if (pkt_rel)
          begin
            pkt_done_q <= 1'b1;
            pkt_cnt_q <= off_q;
            off_q <= '0;
            iso_y_q <= !iso_y_q;
          end
          if (zlp_q)
          begin
            zlp_q <= 1'b0;
            state_q <= S_END;
          end
          else if (xdone && pkt_rel && fullp && ctrl_q.short_packet_select)
          begin
            zlp_q <= 1'b1;
            state_q <= S_WAIT;
          end
          else if (xdone || (pend && !fullp))
          begin
            state_q <= S_END;
          end
          else
          begin
            state_q <= pkt_rel ? S_WAIT : S_CHK;
          end
        end
        S_END:
        begin
          count_q <= moved_q;
          state_q <= ctrl_q.reload_request ? S_RLD : S_IDLE;
        end
        S_RLD:
        begin
          count_q <= RST_REG;
          moved_q <= RST_REG;
          state_q <= (off_q != '0) ? S_CHK : S_WAIT;
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_end_rld;
    state_q == S_END && ctrl_q.reload_request;
  endsequence
  sequence s_end_stop;
    state_q == S_END && !ctrl_q.reload_request;
  endsequence

  reg_swap_a: assert property (s_end_rld |=>
    size_q == $past(rsize_q) && rsize_q == $past(size_q)
    && alo_q == $past(ralo_q)) else $error("reload swap wrong");
  reload_done_a: assert property (s_end_rld |=>
    !ctrl_q.reload_request && flags_q[FLAG_RLD]
    && irq_rld_q == $past(en_q)) else $error("reload report wrong");
  stop_go_a: assert property (s_end_stop |=>
    !ctrl_q.go && flags_q[FLAG_GO] && state_q == S_IDLE)
    else $error("stop did not clear go");
  go_irq_a: assert property (s_end_stop |=>
    irq_go_q == $past(en_q) && !irq_rld_q) else $error("go irq wrong");
  go_clear_a: assert property (state_q == S_IDLE && start |=>
    count_q == 16'h0000 && moved_q == 16'h0000 && state_q == S_WAIT)
    else $error("go did not clear count");
  reload_count_a: assert property (s_end_rld |=> ##1
    count_q == 16'h0000 && moved_q == 16'h0000)
    else $error("count not cleared after reload");
  count_load_a: assert property (state_q == S_END |=>
    count_q == $past(moved_q)) else $error("count not loaded");
  buf_sel_a: assert property (state_q == S_WAIT && pkt_rdy
    && !pkt_done_q && !iso |=> eb_q.sel == $past(pkt_data1))
    else $error("wrong buffer for toggle");
  iso_alt_a: assert property (state_q == S_PKT && pkt_rel |=>
    iso_y_q != $past(iso_y_q)) else $error("iso buffer not alternated");
  save_addr_a: assert property (state_q == S_SVH && mem_q.req |->
    mem_q.we && mem_q.addr == {ahi_q[7:0], alo_q})
    else $error("count saved at wrong address");
  rld_ignore_a: assert property (we_ctrl && wctl.reload_request
    && !wctl.go && !ctrl_q.go |=> !ctrl_q.reload_request)
    else $error("reload set while stopped");
endmodule : ued_dma_channel
`default_nettype wire

/* File: verilog/ued_pkg.sv */
// Constants, types and register map for the endpoint DMA channel
`default_nettype none
package ued_pkg;
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFF_SIZE = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_AHI = 8'h08;
  localparam logic [7:0] OFF_ALO = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_RSIZE = 8'h14;
  localparam logic [7:0] OFF_RAHI = 8'h18;
  localparam logic [7:0] OFF_RALO = 8'h1C;
  localparam logic [7:0] OFF_IRQEN = 8'h20;
  localparam logic [7:0] OFF_FLAGS = 8'h24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam int FLAG_GO = 0;
  localparam int FLAG_RLD = 1;
  localparam logic [23:0] DATA_SKIP = 24'h000002;
  localparam int PKT_W = 10;

  typedef enum logic [9:0] {
    S_IDLE = 10'b0000000001,
    S_WAIT = 10'b0000000010,
    S_CHK = 10'b0000000100,
    S_RD = 10'b0000001000,
    S_WR = 10'b0000010000,
    S_SVH = 10'b0000100000,
    S_SVL = 10'b0001000000,
    S_PKT = 10'b0010000000,
    S_END = 10'b0100000000,
    S_RLD = 10'b1000000000
  } ued_state_t;

  // Control register, go in bit 0
  typedef struct packed {
    logic dir_out;
    logic short_packet_select;
    logic concat_select;
    logic endian;
    logic reload_request;
    logic go;
  } ued_ctrl_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [7:0] data;
  } ued_mem_t;

  typedef struct packed {
    logic req;
    logic we;
    logic sel;
    logic [PKT_W-1:0] idx;
    logic [7:0] data;
  } ued_eb_t;
endpackage : ued_pkg
`default_nettype wire
